// ---- design/itp_pkg.sv ----
// Function
// - enable off: member traffic passes unmetered and unaltered
// - meter only packets whose class is a selected member
// - one token equals one byte of packet length
// - simple bucket admits bursts up to bucket size, its maximum count
// - single-rate mode colours with committed rate, committed and excess burst
// - two-rate mode colours with committed rate and peak rate, each own burst
// - traffic under committed rate gets the green action
// - committed burst size caps the first bucket in every mode
// - excess burst caps second bucket, used only in single-rate mode
// - two-rate mode adds peak-rate bytes per second to second bucket
// - peak burst caps second bucket, peak settings only in two-rate mode
// - green packets pass unchanged or get a configured DSCP rewrite
// - yellow packets pass, drop, or get DSCP 0..63 rewrite and forward
// - rewritten yellow packets are dropped under congestion
// - simple bucket mode never produces yellow
// - packets over excess or peak are red, dropped or rewritten
// - rewritten red packets may be dropped under congestion
// - rewrite sets the six high DS bits, keeps two low bits
package itp_pkg;
    localparam int CLK_HZ = 200000000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / 5;
    localparam int TICKS_PER_S = CLK_HZ / TICK_CYC;
    localparam int TW = 32;
    localparam int LW = 16;
    localparam int CW = 16;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CIR = 8'h04;
    localparam logic [7:0] OFF_CBS = 8'h08;
    localparam logic [7:0] OFF_EBS = 8'h0c;
    localparam logic [7:0] OFF_PIR = 8'h10;
    localparam logic [7:0] OFF_PBS = 8'h14;
    localparam logic [7:0] OFF_ACT = 8'h18;
    localparam logic [7:0] OFF_CLS = 8'h1c;
    localparam logic [7:0] OFF_TOK1 = 8'h20;
    localparam logic [7:0] OFF_TOK2 = 8'h24;
    localparam logic [7:0] OFF_CNT = 8'h28;
    // ctrl fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    // action fields
    localparam int ACT_G_LO = 0;
    localparam int ACT_Y_LO = 2;
    localparam int ACT_R_LO = 4;
    localparam int ACT_GD_LO = 8;
    localparam int ACT_YD_LO = 16;
    localparam int ACT_RD_LO = 24;
    localparam logic [31:0] RST_ZERO = 32'h0;
    localparam logic [31:0] RST_CBS = 32'h0000_2000;
    localparam logic [31:0] RD_UNMAPPED = 32'hdead_0bad;
    typedef enum logic [1:0] {ITP_SIMPLE, ITP_SRTCM, ITP_TRTCM, ITP_RSVD} itp_mode_e;
    typedef enum logic [1:0] {ITP_GREEN, ITP_YELLOW, ITP_RED, ITP_NONE} itp_color_e;
    localparam logic [1:0] ACT_PASS = 2'h0;
    localparam logic [1:0] ACT_DROP = 2'h1;
    localparam logic [1:0] ACT_MARK = 2'h2;
endpackage : itp_pkg

// ---- design/itp_bkt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface itp_bkt_if;
    import itp_pkg::*;
    logic [TW-1:0] max;
    logic [TW-1:0] rate;
    logic tick;
    logic fill;
    logic take;
    logic [LW-1:0] len;
    logic [TW-1:0] level;
    modport owner(input max, rate, tick, fill, take, len, output level);
    modport user(output max, rate, tick, fill, take, len, input level);
endinterface : itp_bkt_if
`default_nettype wire

// ---- design/itp_bucket.sv ----
`timescale 1ns/1ps
`default_nettype none
module itp_bucket (
    input wire logic mclk_i,
    input wire logic rst_i,
    itp_bkt_if.owner b
);
    import itp_pkg::*;
    logic [TW-1:0] lvl_r;
    logic [TW:0] refill;
    logic [TW-1:0] sat;
    logic [TW-1:0] lvl_nxt;
    logic [TW-1:0] base;
    // rate is bytes per second, added in per-tick slices
    assign refill = {1'b0, lvl_r} + {1'b0, b.rate / TW'(TICKS_PER_S)} + 1'b0;
    assign sat = (refill > {1'b0, b.max}) ? b.max : refill[TW-1:0];
    // a take in a tick cycle still keeps that tick's tokens
    assign base = b.tick ? sat : lvl_r;
    assign lvl_nxt = b.fill ? b.max :
        b.take ? base - TW'(b.len) : base;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lvl_r <= RST_CBS;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end
    assign b.level = lvl_r;
    AST_CAP: assert property (@(posedge mclk_i) disable iff (rst_i)
        b.tick && !b.take && !b.fill |=> lvl_r <= $past(b.max))
        else $error("bucket over its cap");
endmodule : itp_bucket
`default_nettype wire

// ---- design/itp_policer.sv ----
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module itp_policer (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic pkt_valid_i,
    input wire logic [itp_pkg::CW-1:0] pkt_class_i,
    input wire logic [itp_pkg::LW-1:0] pkt_len_i,
    input wire logic [7:0] pkt_ds_i,
    input wire logic congested_i,
    output logic out_valid_o,
    output logic out_drop_o,
    output logic [7:0] out_ds_o,
    output logic [1:0] out_color_o
);
    import itp_pkg::*;

    // ================================================================
    // register file
    logic [31:0] ctrl_r, cir_r, cbs_r, ebs_r, pir_r, pbs_r, act_r, cls_r;
    logic [31:0] cnt_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic wait_r;
    logic cfg_chg_r;
    logic acc;
    logic [31:0] rd_mux;
    logic [31:0] wmask;
    logic hit_cfg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_be
            assign wmask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
        end
    endgenerate

    // one wait state: answer at the second edge of the request
    assign acc = (avs_read_i | avs_write_i) & ~ack_r;
    assign hit_cfg = avs_write_i & acc && avs_address_i <= OFF_CLS && avs_address_i[1:0] == 2'h0;

    itp_bkt_if bk1();
    itp_bkt_if bk2();

    always_comb begin
        case (avs_address_i)
            OFF_CTRL: rd_mux = ctrl_r;
            OFF_CIR: rd_mux = cir_r;
            OFF_CBS: rd_mux = cbs_r;
            OFF_EBS: rd_mux = ebs_r;
            OFF_PIR: rd_mux = pir_r;
            OFF_PBS: rd_mux = pbs_r;
            OFF_ACT: rd_mux = act_r;
            OFF_CLS: rd_mux = cls_r;
            OFF_TOK1: rd_mux = bk1.level;
            OFF_TOK2: rd_mux = bk2.level;
            OFF_CNT: rd_mux = cnt_r;
            default: rd_mux = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= RST_ZERO;
        end else begin
            ack_r <= acc;
            wait_r <= ~acc;
            if (acc && avs_read_i) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_r <= RST_ZERO;
            cir_r <= RST_ZERO;
            cbs_r <= RST_CBS;
            ebs_r <= RST_CBS;
            pir_r <= RST_ZERO;
            pbs_r <= RST_CBS;
            act_r <= RST_ZERO;
            cls_r <= RST_ZERO;
            cfg_chg_r <= 1'b0;
        end else begin
            cfg_chg_r <= hit_cfg;
            if (hit_cfg) begin
                case (avs_address_i)
                    OFF_CTRL: ctrl_r <= merge(ctrl_r, avs_writedata_i, wmask);
                    OFF_CIR: cir_r <= merge(cir_r, avs_writedata_i, wmask);
                    OFF_CBS: cbs_r <= merge(cbs_r, avs_writedata_i, wmask);
                    OFF_EBS: ebs_r <= merge(ebs_r, avs_writedata_i, wmask);
                    OFF_PIR: pir_r <= merge(pir_r, avs_writedata_i, wmask);
                    OFF_PBS: pbs_r <= merge(pbs_r, avs_writedata_i, wmask);
                    OFF_ACT: act_r <= merge(act_r, avs_writedata_i, wmask);
                    OFF_CLS: cls_r <= merge(cls_r, avs_writedata_i, wmask);
                    default: ;
                endcase
            end
        end
    end

    assign avs_readdata_o = rdata_r;
    // own flop so the pin never passes through a gate
    assign avs_waitrequest_o = wait_r;

    // ================================================================
    // decoded configuration
    logic en;
    itp_mode_e mode;
    logic [1:0] g_act, y_act, r_act;
    logic [5:0] g_dscp, y_dscp, r_dscp;
    assign en = ctrl_r[CTRL_EN];
    assign mode = itp_mode_e'(ctrl_r[CTRL_MODE_LO +: 2]);
    assign g_act = act_r[ACT_G_LO +: 2];
    assign y_act = act_r[ACT_Y_LO +: 2];
    assign r_act = act_r[ACT_R_LO +: 2];
    assign g_dscp = act_r[ACT_GD_LO +: 6];
    assign y_dscp = act_r[ACT_YD_LO +: 6];
    assign r_dscp = act_r[ACT_RD_LO +: 6];

    // ================================================================
    // refill tick
    logic [15:0] tick_cnt_r;
    logic tick;
    assign tick = tick_cnt_r == 16'(TICK_CYC - 1);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tick_cnt_r <= 16'h0;
        end else begin
            tick_cnt_r <= tick ? 16'h0 : tick_cnt_r + 16'h1;
        end
    end

    // ================================================================
    // metering
    logic member;
    logic metered;
    logic fits1, fits2;
    itp_color_e color;
    logic take1, take2;
    // classes are one-hot member bits; class index above 31 never matches
    assign member = pkt_class_i < CW'(32) && cls_r[pkt_class_i[4:0]];
    assign metered = pkt_valid_i & en & member;
    assign fits1 = bk1.level >= TW'(pkt_len_i);
    assign fits2 = bk2.level >= TW'(pkt_len_i);

    always_comb begin
        case (mode)
            ITP_SIMPLE: color = fits1 ? ITP_GREEN : ITP_RED;
            ITP_SRTCM: color = fits1 ? ITP_GREEN :
                fits2 ? ITP_YELLOW : ITP_RED;
            ITP_TRTCM: color = !fits2 ? ITP_RED :
                fits1 ? ITP_GREEN : ITP_YELLOW;
            default: color = ITP_RED;
        endcase
    end

    // srTCM: second bucket spends on yellow; trTCM: on green and yellow
    assign take1 = metered && color == ITP_GREEN;
    assign take2 = metered && ((mode == ITP_SRTCM && color == ITP_YELLOW) ||
        (mode == ITP_TRTCM && color != ITP_RED));

    assign bk1.max = cbs_r;
    assign bk1.rate = cir_r;
    assign bk1.tick = tick;
    assign bk1.fill = cfg_chg_r;
    assign bk1.take = take1;
    assign bk1.len = pkt_len_i;
    // srTCM excess bucket refills on its own at committed rate, not from overflow, simplified
    assign bk2.max = (mode == ITP_TRTCM) ? pbs_r : ebs_r;
    assign bk2.rate = (mode == ITP_TRTCM) ? pir_r : cir_r;
    assign bk2.tick = tick && (mode == ITP_SRTCM || mode == ITP_TRTCM);
    assign bk2.fill = cfg_chg_r;
    assign bk2.take = take2;
    assign bk2.len = pkt_len_i;

    itp_bucket u_bk1 (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .b(bk1.owner)
    );
    itp_bucket u_bk2 (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .b(bk2.owner)
    );

    // ================================================================
    // actions
    logic [1:0] sel_act;
    logic [5:0] sel_dscp;
    logic do_mark, do_drop;
    logic [7:0] ds_new;
    assign sel_act = (color == ITP_GREEN) ? (g_act == ACT_MARK ? ACT_MARK : ACT_PASS) :
        (color == ITP_YELLOW) ? y_act :
        (r_act == ACT_MARK ? ACT_MARK : ACT_DROP);
    assign sel_dscp = (color == ITP_GREEN) ? g_dscp :
        (color == ITP_YELLOW) ? y_dscp : r_dscp;
    assign do_mark = metered && sel_act == ACT_MARK;
    // marked yellow and red fall to congestion
    assign do_drop = metered && (sel_act == ACT_DROP ||
        (do_mark && color != ITP_GREEN && congested_i));
    assign ds_new = do_mark ? {sel_dscp, pkt_ds_i[1:0]} : pkt_ds_i;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_drop_o <= 1'b0;
            out_ds_o <= 8'h0;
            out_color_o <= ITP_NONE;
            cnt_r <= RST_ZERO;
        end else begin
            out_valid_o <= pkt_valid_i;
            out_drop_o <= do_drop;
            out_ds_o <= ds_new;
            out_color_o <= metered ? color : ITP_NONE;
            if (metered && do_drop) begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    // ================================================================
    // checks
    AST_OFF_PASS: assert property (@(posedge mclk_i) disable iff (rst_i)
        pkt_valid_i && !en |=> out_valid_o && !out_drop_o && out_ds_o == $past(pkt_ds_i))
        else $error("disabled policer altered traffic");
    AST_NONMEMBER: assert property (@(posedge mclk_i) disable iff (rst_i)
        pkt_valid_i && !member |=> out_color_o == ITP_NONE && !out_drop_o)
        else $error("non-member packet metered");
    AST_NO_YELLOW: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SIMPLE |=> out_color_o != ITP_YELLOW)
        else $error("yellow in simple mode");
    AST_GREEN_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_GREEN |=> !out_drop_o)
        else $error("green packet dropped");
    AST_LOW_BITS: assert property (@(posedge mclk_i) disable iff (rst_i)
        pkt_valid_i |=> out_ds_o[1:0] == $past(pkt_ds_i[1:0]))
        else $error("unused DS bits changed");
    AST_RED_CONG: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_RED && congested_i |=> out_drop_o)
        else $error("red under congestion forwarded");
    AST_YMARK: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_YELLOW && y_act == ACT_MARK && !congested_i
        |=> !out_drop_o && out_ds_o[7:2] == $past(y_dscp))
        else $error("yellow rewrite wrong");
    AST_REFILL: assert property (@(posedge mclk_i) disable iff (rst_i)
        cfg_chg_r |=> bk1.level == $past(cbs_r))
        else $error("bucket not refilled on config change");
    AST_WAIT: assert property (@(posedge mclk_i) disable iff (rst_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");

    // ================================================================
    // checks: bus
    AST_WAIT_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer stood two cycles");
    AST_RD_DATA: assert property (@(posedge mclk_i) disable iff (rst_i)
        avs_read_i && avs_waitrequest_o |=> avs_readdata_o == $past(rd_mux))
        else $error("read data not loaded");
    AST_RD_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data moved");
    AST_RO_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
        avs_write_i && avs_address_i > OFF_CLS |=> !cfg_chg_r)
        else $error("read-only write acted");
    AST_WR_TAKE: assert property (@(posedge mclk_i) disable iff (rst_i)
        hit_cfg && avs_address_i == OFF_CTRL && avs_byteenable_i == 4'hf
        |=> ctrl_r == $past(avs_writedata_i))
        else $error("control write lost");

    // ================================================================
    // checks: colouring
    AST_SMP_GREEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SIMPLE && fits1 |=> out_color_o == ITP_GREEN)
        else $error("simple fit not green");
    AST_SMP_RED: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SIMPLE && !fits1 |=> out_color_o == ITP_RED)
        else $error("simple overflow not red");
    AST_SR_GREEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SRTCM && fits1 |=> out_color_o == ITP_GREEN)
        else $error("srTCM green wrong");
    AST_SR_YELLOW: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SRTCM && !fits1 && fits2 |=> out_color_o == ITP_YELLOW)
        else $error("srTCM yellow wrong");
    AST_SR_RED: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_SRTCM && !fits1 && !fits2 |=> out_color_o == ITP_RED)
        else $error("srTCM red wrong");
    AST_TR_GREEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_TRTCM && fits1 && fits2 |=> out_color_o == ITP_GREEN)
        else $error("trTCM green wrong");
    AST_TR_YELLOW: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_TRTCM && fits2 && !fits1 |=> out_color_o == ITP_YELLOW)
        else $error("trTCM yellow wrong");
    AST_TR_RED: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && mode == ITP_TRTCM && !fits2 |=> out_color_o == ITP_RED)
        else $error("trTCM red wrong");

    // ================================================================
    // checks: actions
    AST_GREEN_MARK: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_GREEN && g_act == ACT_MARK |=> out_ds_o[7:2] == $past(g_dscp))
        else $error("green rewrite wrong");
    AST_GREEN_PASS: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_GREEN && g_act != ACT_MARK |=> out_ds_o == $past(pkt_ds_i))
        else $error("green pass altered");
    AST_YPASS: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_YELLOW && y_act == ACT_PASS
        |=> !out_drop_o && out_ds_o == $past(pkt_ds_i))
        else $error("yellow pass wrong");
    AST_YDROP: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_YELLOW && y_act == ACT_DROP |=> out_drop_o)
        else $error("yellow drop missed");
    AST_YMARK_CONG: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_YELLOW && y_act == ACT_MARK && congested_i |=> out_drop_o)
        else $error("rewritten yellow kept");
    AST_RED_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_RED && r_act != ACT_MARK |=> out_drop_o)
        else $error("red drop missed");
    AST_RMARK: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && color == ITP_RED && r_act == ACT_MARK && !congested_i
        |=> !out_drop_o && out_ds_o[7:2] == $past(r_dscp))
        else $error("red rewrite wrong");

    // ================================================================
    // checks: buckets and counter
    AST_REFILL2: assert property (@(posedge mclk_i) disable iff (rst_i)
        cfg_chg_r |=> bk2.level == $past(bk2.max))
        else $error("second bucket not refilled");
    AST_CNT: assert property (@(posedge mclk_i) disable iff (rst_i)
        metered && do_drop |=> cnt_r == $past(cnt_r) + 32'h1)
        else $error("drop count missed");
    AST_BK2_SIMPLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        mode == ITP_SIMPLE |-> !take2 && !bk2.tick)
        else $error("second bucket used in simple mode");
endmodule : itp_policer
`default_nettype wire

// ---- verification/itp_pkt_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// classifier side model
module itp_pkt_src (
    input wire logic mclk_i,
    input wire logic send_i,
    input wire logic [itp_pkg::CW-1:0] cls_i,
    input wire logic [itp_pkg::LW-1:0] len_i,
    input wire logic [7:0] ds_i,
    output logic pkt_valid_o,
    output logic [itp_pkg::CW-1:0] pkt_class_o,
    output logic [itp_pkg::LW-1:0] pkt_len_o,
    output logic [7:0] pkt_ds_o
);
    import itp_pkg::*;
    logic [CW+LW+7:0] last_r = '0;
    // idle fields flip each cycle so stale values never look valid
    always_ff @(posedge mclk_i) begin
        last_r <= send_i ? {cls_i, len_i, ds_i} : ~last_r;
    end
    assign pkt_valid_o = send_i;
    assign {pkt_class_o, pkt_len_o, pkt_ds_o} = send_i ? {cls_i, len_i, ds_i} : ~last_r;
endmodule : itp_pkt_src
`default_nettype wire

// ---- verification/itp_policer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module itp_policer_tb_top;
    import itp_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic wreq;
    logic send = 1'b0;
    logic [CW-1:0] cls = '0;
    logic [LW-1:0] len = '0;
    logic [7:0] ds = '0;
    logic cong = 1'b0;
    logic [3:0] be = 4'hf;
    logic pv;
    logic [CW-1:0] pc;
    logic [LW-1:0] pl;
    logic [7:0] pd;
    logic ov;
    logic od;
    logic [7:0] ods;
    logic [1:0] oc;
    int n_errors = 0;
    int num_checks = 0;
    int n_drop = 0;
    int t1;
    int t2;
    logic [1:0] md;
    logic en;
    logic [31:0] act_v;
    logic [31:0] map_v;

    always #2.5 mclk_i = ~mclk_i;

    itp_pkt_src i_src (.mclk_i(mclk_i), .send_i(send), .cls_i(cls), .len_i(len), .ds_i(ds),
        .pkt_valid_o(pv), .pkt_class_o(pc), .pkt_len_o(pl), .pkt_ds_o(pd));
    itp_policer i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pkt_valid_i(pv), .pkt_class_i(pc),
        .pkt_len_i(pl), .pkt_ds_i(pd), .congested_i(cong), .out_valid_o(ov),
        .out_drop_o(od), .out_ds_o(ods), .out_color_o(oc));

    // ==========
    // reporting
    task give_verdict;
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    // ==========
    // bus master: hold until waitrequest seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge mclk_i);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdat <= d;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (wreq !== 1'b0 && k < 64);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 64) begin
            n_errors++;
            give_verdict();
        end
    endtask : bus

    task wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(nm, e, q);
    endtask : rchk

    // ==========
    // expected verdict: {drop, colour, ds}, updates the token model
    function automatic logic [10:0] expect_pkt(input logic [CW-1:0] c_in, input int l,
                                               input logic [7:0] d_in, input logic cg);
        logic [1:0] c;
        logic mk;
        if (!en || c_in > 31 || !map_v[c_in[4:0]]) return {1'b0, 2'h3, d_in};
        c = ITP_RED;
        if (md == 2'h2) begin
            if (t2 >= l && t1 >= l) begin
                c = ITP_GREEN;
                t1 -= l;
                t2 -= l;
            end else if (t2 >= l) begin
                c = ITP_YELLOW;
                t2 -= l;
            end
        end else if (t1 >= l) begin
            c = ITP_GREEN;
            t1 -= l;
        end else if (md == 2'h1 && t2 >= l) begin
            c = ITP_YELLOW;
            t2 -= l;
        end
        mk = (act_v[2*c +: 2] == ACT_MARK);
        return {(c == ITP_GREEN) ? 1'b0 : mk ? cg : (c == ITP_RED || act_v[2*c +: 2] == ACT_DROP),
                c, mk ? {act_v[8*c+8 +: 6], d_in[1:0]} : d_in};
    endfunction : expect_pkt

    task pkt(input logic [CW-1:0] c_in, input int l);
        logic [10:0] e;
        logic [7:0] d;
        logic g;
        d = 8'($urandom);
        g = 1'($urandom);
        e = expect_pkt(c_in, l, d, g);
        if (e[10]) n_drop++;
        @(posedge mclk_i);
        send <= 1'b1;
        cls <= c_in;
        len <= LW'(l);
        ds <= d;
        cong <= g;
        @(posedge mclk_i);
        send <= 1'b0;
        #1;
        chk("out_valid", 32'h1, {31'h0, ov});
        chk("out_color", {30'h0, e[9:8]}, {30'h0, oc});
        chk("out_drop", {31'h0, e[10]}, {31'h0, od});
        if (!e[10]) chk("out_ds", {24'h0, e[7:0]}, {24'h0, ods});
    endtask : pkt

    // ==========
    // main sequence
    initial begin
        logic [31:0] cbs;
        logic [31:0] b2;
        logic [31:0] q;
        void'($urandom(32'h5540));
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk("ctrl", OFF_CTRL, RST_ZERO);
        rchk("cbs", OFF_CBS, RST_CBS);
        rchk("tok1", OFF_TOK1, RST_CBS);
        rchk("unmapped", 8'h40, RD_UNMAPPED);
        // only the two low lanes may land
        be <= 4'h3;
        wreg(OFF_ACT, 32'hffff_ffff);
        be <= 4'hf;
        rchk("act_lanes", OFF_ACT, 32'h0000_ffff);
        for (int i = 0; i < 8; i++) begin
            md = (i == 0) ? 2'h0 : (i < 4) ? 2'h1 : 2'h2;
            en = (i != 7);
            cbs = 200 + $urandom_range(500);
            // second burst kept at or above the committed burst
            b2 = cbs + $urandom_range(700);
            act_v = {2'h0, 6'($urandom), 2'h0, 6'($urandom), 2'h0, 6'($urandom), 2'h0,
                     i[1] ? ACT_MARK : ACT_DROP, 2'(i % 3), i[0] ? ACT_MARK : ACT_PASS};
            map_v = 32'h1 << (i + 3);
            wreg(OFF_CIR, RST_ZERO);
            wreg(OFF_PIR, RST_ZERO);
            wreg(OFF_EBS, b2);
            wreg(OFF_PBS, b2);
            wreg(OFF_CBS, cbs);
            wreg(OFF_ACT, act_v);
            wreg(OFF_CLS, map_v);
            wreg(OFF_CTRL, {29'h0, md, en});
            t1 = cbs;
            t2 = b2;
            rchk("tok1", OFF_TOK1, cbs);
            repeat (14) pkt(CW'(($urandom_range(5) == 0) ? i + 4 : i + 3), 1 + $urandom_range(299));
            rchk("tok1", OFF_TOK1, t1);
            if (md != 2'h0 && en) rchk("tok2", OFF_TOK2, t2);
            rchk("drop_cnt", OFF_CNT, n_drop);
        end
        md = 2'h2;
        en = 1'b1;
        wreg(OFF_CIR, 32'h002d_c6c0);
        wreg(OFF_PIR, 32'h003d_0900);
        wreg(OFF_CBS, 32'h0000_0100);
        wreg(OFF_PBS, 32'h0000_0100);
        wreg(OFF_CTRL, {29'h0, md, en});
        t1 = 256;
        t2 = 256;
        pkt(CW'(10), 256);
        // tick phase is unknown, so allow two ticks either way for tok1, one below and two above for tok2
        repeat (8000) @(posedge mclk_i);
        bus(1'b0, OFF_TOK1, '0, q);
        num_checks++;
        if ((q >= 114 && q <= 126) !== 1'b1) begin
            $display("wrong value tok1_refill expected 120 seen %0d", q);
            n_errors++;
        end
        bus(1'b0, OFF_TOK2, '0, q);
        num_checks++;
        if ((q >= 156 && q <= 168) !== 1'b1) begin
            $display("wrong value tok2_refill expected 160 seen %0d", q);
            n_errors++;
        end
        // mid-run reset must refill the drained buckets
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk("tok1_rst", OFF_TOK1, RST_CBS);
        rchk("cnt_rst", OFF_CNT, RST_ZERO);
        give_verdict();
    end
endmodule : itp_policer_tb_top
`default_nettype wire
